// >>> sim/mct_line_src.sv
// Line-side source that sends code groups first bit first.
// Assumes the caller chains groups back to back within a frame.
`timescale 1ns/1ps

module mct_line_src (
  output logic line_clk,
  output logic line_bit
);
  initial begin
    line_clk = 1'b0;
    line_bit = 1'b0;
  end
  // The 12 ns clock runs only while a group is sent.
  task send(input logic [4:0] g);
    for (int i = 4; i >= 0; i--) begin
      line_bit = g[i];
      #6 line_clk = 1'b1;
      #6 line_clk = 1'b0;
    end
  endtask
  // A released line must not keep showing the last bit.
  task idle;
    line_bit = ~line_bit;
  endtask
endmodule

// >>> sim/mct_phy_timing_properties.sv
// Concurrent checks on the ports of the PHY timing block.
// Assumes short simulation counts passed in through the bind.
`timescale 1ns/1ps

module mct_phy_timing_props #(
  parameter int POR_CYC    = 50,
  parameter int HWR_CYC    = 40,
  parameter int JAB_ON_CYC = 2000
) (
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic       hw_reset_low,
  input wire logic       mac_tx_en,
  input wire logic       speed_100,
  input wire logic       full_duplex,
  input wire logic       line_transmit_pair,
  input wire logic       mii_tx_clk,
  input wire logic       mii_crs,
  input wire logic       mii_col,
  input wire logic [4:0] rx_symbol,
  input wire logic       rx_valid,
  input wire logic       rx_ready
);
  logic run;      // Transmit clock seen since the last pin reset.
  logic clk_q;    // Previous transmit clock level.
  int   quiet;    // Cycles without a transmit clock edge.
  int   sqe_cnt;  // Length of a collision pulse after enable fell.
  int   tx_cnt;   // Continuous 10M half-duplex transmit cycles.
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // A pin reset stops the clock, so run must be earned again.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) run <= 1'b0;
    else if (!hw_reset_low) run <= 1'b0;
    else if (mii_tx_clk) run <= 1'b1;
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clk_q <= 1'b0;
      quiet <= 0;
    end else begin
      clk_q <= mii_tx_clk;
      quiet <= (!hw_reset_low || mii_tx_clk != clk_q) ? 0 : quiet + 1;
    end
  end
  // Pulse length counts only with enable low, so jabber is not mistaken for it.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) sqe_cnt <= 0;
    else sqe_cnt <= (mii_col && !mac_tx_en) ? sqe_cnt + 1 : 0;
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) tx_cnt <= 0;
    else tx_cnt <= (run && mac_tx_en && !speed_100 && !full_duplex) ? tx_cnt + 1 : 0;
  end
  a_crs_rise: assert property (run && !full_duplex && $rose(mac_tx_en) |-> ##[1:6] mii_crs)
    else $error("carrier late after transmit enable");
  a_crs_fall: assert property (run && !full_duplex && !speed_100 && $fell(mac_tx_en) |-> ##[1:42] !mii_crs)
    else $error("carrier held too long");
  a_sqe_start: assert property (run && !full_duplex && !speed_100 && $fell(mac_tx_en) |-> ##[1:152] mii_col)
    else $error("heartbeat missing");
  a_sqe_len: assert property (sqe_cnt <= 152)
    else $error("heartbeat too long");
  a_jab_entry: assert property (tx_cnt == JAB_ON_CYC * 7 / 5 |-> mii_col)
    else $error("jabber not entered");
  a_jab_early: assert property (tx_cnt > 8 && tx_cnt < JAB_ON_CYC * 4 / 5 |-> !mii_col)
    else $error("jabber entered early");
  a_jab_hold: assert property (mii_col && $past(mii_col) && tx_cnt > 8 |-> !line_transmit_pair)
    else $error("line driven in jabber");
  a_hw_iso: assert property (!hw_reset_low [*6] |-> !mii_tx_clk && !mii_crs && !mii_col && !line_transmit_pair)
    else $error("not isolated in pin reset");
  a_col_crs: assert property (speed_100 && mii_col |-> mii_crs)
    else $error("collision without carrier");
  a_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_symbol))
    else $error("receive word lost in stall");
  a_clk_alive: assert property (quiet < POR_CYC + HWR_CYC + 40)
    else $error("transmit clock missing");
endmodule

bind mct_phy_timing mct_phy_timing_props #(.POR_CYC(POR_CYC), .HWR_CYC(HWR_CYC), .JAB_ON_CYC(JAB_ON_CYC)) props_i (
  .mclk, .nrst, .hw_reset_low, .mac_tx_en, .speed_100, .full_duplex, .line_transmit_pair,
  .mii_tx_clk, .mii_crs, .mii_col, .rx_symbol, .rx_valid, .rx_ready);

// >>> sim/test_mii_phy_carrier_reset_timing.sv
// Self-checking bench for the PHY timing block.
// Assumes the line source model and the bound checker.
`timescale 1ns/1ps

module test_mii_phy_carrier_reset_timing;
  logic mclk = 0, nrst = 0, hw_reset_low = 1, mac_tx_en = 0, speed_100 = 1, full_duplex = 0, rx_ready = 1;
  logic line_clk, line_bit, line_transmit_pair, mii_tx_clk, mii_crs, mii_col, rx_valid, rx_overrun, col_hit;
  logic [4:0] rx_symbol;
  int   err_total = 0, total_checks = 0, cyc = 0, n;
  // Rows hold speed, duplex, expected carrier echo, expected heartbeat.
  logic [3:0] rows [4] = '{4'b1010, 4'b1100, 4'b0011, 4'b0100};
  always #5 mclk = ~mclk;
  mct_phy_timing #(.POR_CYC(50), .HWR_CYC(40), .JAB_ON_CYC(2000), .JAB_OFF_CYC(4000)) mct_phy_timing_i (
    .mclk, .nrst, .line_clk, .hw_reset_low, .mac_tx_en, .speed_100, .full_duplex,
    .line_receive_pair(line_bit), .line_transmit_pair, .mii_tx_clk, .mii_crs, .mii_col,
    .rx_symbol, .rx_valid, .rx_ready, .rx_overrun);
  mct_line_src mct_line_src_i (.line_clk, .line_bit);
  always @(posedge mclk) if (mii_col === 1'b1) col_hit <= 1'b1;
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      close_out;
    end
  end
  task wt(input int k); repeat (k) @(posedge mclk); endtask
  task tx(input logic v); @(posedge mclk); mac_tx_en <= v; endtask
  task chk(input string nm, input logic [4:0] e, input logic [4:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wclk;
    n = 0;
    while (mii_tx_clk !== 1'b1 && n < 200) begin wt(1); n++; end
    chk("tx_clk", 1, mii_tx_clk);
  endtask
  task frame;
    mct_line_src_i.send(mct_pkg::SYM_J);
    foreach (rows[i]) mct_line_src_i.send(5'h0E + 5'(i * 5));
    mct_line_src_i.send(mct_pkg::SYM_T);
    mct_line_src_i.idle;
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    wt(20);
    nrst <= 1'b1;
    // The line side leaves its own reset only after two line clock edges, so idle bits go first.
    mct_line_src_i.send(5'h00);
    wclk;
    foreach (rows[i]) begin
      speed_100 <= rows[i][3];
      full_duplex <= rows[i][2];
      wt(40);
      tx(1);
      wt(20);
      chk("crs_on", rows[i][1], mii_crs);
      tx(0);
      n = 0;
      for (int k = 0; k < 200; k++) begin
        wt(1);
        n += mii_col;
        if (k == 44) chk("crs_off", 0, mii_crs);
      end
      chk("sqe", rows[i][0], n > 90 && n <= 150);
    end
    // Receive while transmitting at 100M half duplex.
    speed_100 <= 1'b1;
    full_duplex <= 1'b0;
    wt(40);
    tx(1);
    col_hit = 1'b0;
    frame;
    chk("col_on", 1, col_hit);
    wt(25);
    chk("col_off", 0, mii_col);
    tx(0);
    wt(30);
    chk("crs_rx_off", 0, mii_crs);
    // Stalled receiver: buffer fills, a group is refused, then drained.
    rx_ready <= 1'b0;
    frame;
    wt(1);
    chk("crs_rx_on", 1, mii_crs);
    wt(9);
    chk("rx_valid", 1, rx_valid);
    chk("rx_start", mct_pkg::SYM_J, rx_symbol);
    chk("overrun", 1, rx_overrun);
    rx_ready <= 1'b1;
    wt(1);
    rx_ready <= 1'b0;
    wt(6);
    chk("rx_next", 5'h0E, rx_symbol);
    rx_ready <= 1'b1;
    wt(20);
    chk("rx_empty", 0, rx_valid);
    // Pin reset of 610 ns while the MAC transmits.
    hw_reset_low <= 1'b0;
    tx(1);
    wt(10);
    n = 0;
    repeat (50) begin wt(1); n += mii_tx_clk | line_transmit_pair | mii_crs; end
    chk("isolate", 0, n != 0);
    hw_reset_low <= 1'b1;
    wclk;
    tx(0);
    // Jabber at 10M half duplex.
    speed_100 <= 1'b0;
    wt(300);
    tx(1);
    n = 0;
    while (mii_col !== 1'b1 && n < 3000) begin wt(1); n++; end
    chk("jab_on", 1, n >= 1600 && n < 2800);
    wt(2);
    chk("jab_line", 0, line_transmit_pair);
    wt(3800);
    chk("jab_hold", 1, mii_col);
    wt(450);
    chk("jab_off", 0, mii_col);
    tx(0);
    wt(200);
    close_out;
  end
endmodule

// >>> src/mct_fifo2.sv
// Holds a small first-in first-out buffer with valid and ready on both sides.
// Assumes one clock; the depth is a parameter and defaults to two entries.
`timescale 1ns/1ps

module mct_fifo2 #(
  parameter int WIDTH = 5,  // Word width.
  parameter int DEPTH = 2   // Number of entries.
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  // ---------------------------------------------------------------------------
  // Storage and pointers
  // ---------------------------------------------------------------------------
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;  // Pointer width.

  logic [WIDTH-1:0] mem [DEPTH];  // Entry storage.
  logic [AW-1:0]    wr_ptr;       // Next slot to fill.
  logic [AW-1:0]    rd_ptr;       // Next slot to drain.
  logic [AW:0]      count;        // Entries held.
  logic             push;         // A word enters this cycle.
  logic             pop;          // A word leaves this cycle.

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  // Write side: the slot is written only when a word is really taken.
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
    end
  end

  // Fill level, so full and empty are exact even when both sides move at once.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= count + 1'b1;
    end else if (pop && !push) begin
      count <= count - 1'b1;
    end
  end

endmodule

// >>> src/mct_phy_timing.sv
// Holds the carrier, collision (at 100 Mb/s only), heartbeat, jabber and reset timing of a 10/100 PHY toward its MAC.
// Assumes the MAC drives transmit enable asynchronously to mclk and the line bits arrive on line_clk.
`timescale 1ns/1ps

module mct_phy_timing #(
  parameter int POR_MS     = 45,   // Power-on reset length in ms.
  parameter int HWR_MS     = 35,   // Release of reset pin to valid transmit clock, in ms.
  parameter int JAB_ON_MS  = 25,   // Continuous transmission before jabber, in ms.
  parameter int JAB_OFF_MS = 310,  // Jabber de-activation interval, in ms.
  parameter int POR_CYC     = POR_MS * mct_pkg::CYC_PER_MS,
  parameter int HWR_CYC     = HWR_MS * mct_pkg::CYC_PER_MS,
  parameter int JAB_ON_CYC  = JAB_ON_MS * mct_pkg::CYC_PER_MS,
  parameter int JAB_OFF_CYC = JAB_OFF_MS * mct_pkg::CYC_PER_MS,
  parameter int BUF_DEPTH   = 2    // Receive buffer depth.
) (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       line_clk,
  input  wire logic       hw_reset_low,
  input  wire logic       mac_tx_en,
  input  wire logic       speed_100,
  input  wire logic       full_duplex,
  input  wire logic       line_receive_pair,
  output logic            line_transmit_pair,
  output logic            mii_tx_clk,
  output logic            mii_crs,
  output logic            mii_col,
  output logic [4:0]      rx_symbol,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic            rx_overrun
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers in the system domain
  // ---------------------------------------------------------------------------
  logic [1:0] tx_sync;    // Transmit enable, two stages.
  logic [1:0] rst_sync;   // Reset pin, two stages.
  logic [1:0] spd_sync;   // Speed strap, two stages.
  logic [1:0] fdx_sync;   // Duplex strap, two stages.
  logic       tx_en;      // Synchronised transmit enable.
  logic       tx_en_d;    // Transmit enable one cycle older, for edges.
  logic       fast;       // Synchronised 100 Mb/s select.
  logic       half;       // Synchronised half-duplex select.

  // Each pin passes two flops before any logic looks at it.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tx_sync  <= '0;
      rst_sync <= '0;
      spd_sync <= '0;
      fdx_sync <= '0;
      tx_en_d  <= 1'b0;
    end else begin
      tx_sync  <= {tx_sync[0], mac_tx_en};
      rst_sync <= {rst_sync[0], hw_reset_low};
      spd_sync <= {spd_sync[0], speed_100};
      fdx_sync <= {fdx_sync[0], full_duplex};
      tx_en_d  <= tx_sync[1];
    end
  end

  assign tx_en = tx_sync[1];
  assign fast  = spd_sync[1];
  assign half  = !fdx_sync[1];

  // ---------------------------------------------------------------------------
  // Reset sequencing
  // ---------------------------------------------------------------------------
  mct_pkg::mct_state_t state;      // Sequencer state.
  logic [25:0]         init_cnt;   // Cycles left in the current wait.
  logic                run;        // Device is out of reset and not isolated.

  // The pin synchroniser reads low after reset, so ST_POR passes to ST_HOLD at once without counting; the pin can interrupt any state.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state    <= mct_pkg::ST_POR;
      init_cnt <= 26'(POR_CYC);
    end else begin
      case (state)
        mct_pkg::ST_POR: begin
          if (!rst_sync[1]) begin
            state <= mct_pkg::ST_HOLD;
          end else if (init_cnt == '0) begin
            state <= mct_pkg::ST_RUN;
          end else begin
            init_cnt <= init_cnt - 1'b1;
          end
        end
        mct_pkg::ST_HOLD: begin
          init_cnt <= 26'(HWR_CYC);
          if (rst_sync[1]) begin
            state <= mct_pkg::ST_INIT;
          end
        end
        mct_pkg::ST_INIT: begin
          if (!rst_sync[1]) begin
            state <= mct_pkg::ST_HOLD;
          end else if (init_cnt == '0) begin
            state <= mct_pkg::ST_RUN;
          end else begin
            init_cnt <= init_cnt - 1'b1;
          end
        end
        mct_pkg::ST_RUN: begin
          if (!rst_sync[1]) begin
            state <= mct_pkg::ST_HOLD;
          end
        end
        default: begin
          state <= mct_pkg::ST_HOLD;
        end
      endcase
    end
  end

  assign run = (state == mct_pkg::ST_RUN);

  // ---------------------------------------------------------------------------
  // Transmit clock toward the MAC
  // ---------------------------------------------------------------------------
  logic [4:0] div_cnt;   // Cycles into the current half period.
  logic [4:0] div_half;  // Half period for the selected speed.

  assign div_half = fast ? 5'(mct_pkg::TXCLK100_HALF) : 5'(mct_pkg::TXCLK10_HALF);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div_cnt    <= '0;
      mii_tx_clk <= 1'b0;
    end else if (!run) begin
      div_cnt    <= '0;
      mii_tx_clk <= 1'b0;
    end else if (div_cnt >= div_half - 1'b1) begin
      div_cnt    <= '0;
      mii_tx_clk <= !mii_tx_clk;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Transmit carrier echo
  // ---------------------------------------------------------------------------
  logic [4:0] tx_hold;   // Cycles the echo stays up after enable falls.
  logic       tx_echo;   // Carrier caused by the MAC's own transmission.

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tx_hold <= '0;
      tx_echo <= 1'b0;
    end else begin
      if (tx_en) begin
        tx_hold <= fast ? 5'(mct_pkg::TX100_OFF_CYC) : 5'(mct_pkg::TX10_OFF_CYC);
        tx_echo <= 1'b1;
      end else if (tx_hold > 5'h1) begin
        tx_hold <= tx_hold - 1'b1;
      end else begin
        tx_hold <= '0;
        tx_echo <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Line receive domain
  // ---------------------------------------------------------------------------
  logic [1:0] lrst_sync;  // Reset release into the line domain.
  logic       lrst_n;     // Line-domain reset, released synchronously.
  logic [4:0] lshift;     // Last five line bits.
  logic [2:0] lbit;       // Bits into the current code group.
  logic       lframe;     // Inside a stream.
  logic       ltog_j;     // Toggles on each start code.
  logic       ltog_t;     // Toggles on each end code.
  logic       lreq;       // Word request toggle.
  logic [4:0] lword;      // Word held stable for the crossing.
  logic       lreq_ack;   // Acknowledge toggle from the system side.
  logic [1:0] lack_sync;  // Acknowledge toggle, two stages.
  logic       lover;      // A group was dropped because the crossing was busy.
  logic [4:0] lnext;      // Shift register after this bit.

  assign lnext = {lshift[3:0], line_receive_pair};

  // Reset asserts at once and releases on a line clock edge.
  always_ff @(posedge line_clk or negedge nrst) begin
    if (!nrst) begin
      lrst_sync <= '0;
    end else begin
      lrst_sync <= {lrst_sync[0], 1'b1};
    end
  end

  assign lrst_n = lrst_sync[1];

  // The line cannot be paused, so a group that finds the crossing busy is dropped and flagged.
  always_ff @(posedge line_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      lshift    <= '0;
      lbit      <= '0;
      lframe    <= 1'b0;
      ltog_j    <= 1'b0;
      ltog_t    <= 1'b0;
      lreq      <= 1'b0;
      lword     <= '0;
      lack_sync <= '0;
      lover     <= 1'b0;
    end else begin
      lshift    <= lnext;
      lack_sync <= {lack_sync[0], lreq_ack};
      if (!lframe) begin
        if (lnext == mct_pkg::SYM_J) begin
          lframe <= 1'b1;
          lbit   <= '0;
          ltog_j <= !ltog_j;
        end
      end else if (lbit == 3'(mct_pkg::SYM_BITS - 1)) begin
        lbit <= '0;
        if (lnext == mct_pkg::SYM_T) begin
          lframe <= 1'b0;
          ltog_t <= !ltog_t;
        end
      end else begin
        lbit <= lbit + 1'b1;
      end
      if (lnext == mct_pkg::SYM_J && !lframe || lframe && lbit == 3'(mct_pkg::SYM_BITS - 1)) begin
        if (lack_sync[1] == lreq) begin
          lword <= lnext;
          lreq  <= !lreq;
        end else begin
          lover <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Crossing into the system domain
  // ---------------------------------------------------------------------------
  logic [2:0] j_sync;     // Start toggle, two stages plus edge history.
  logic [2:0] t_sync;     // End toggle, two stages plus edge history.
  logic [1:0] req_sync;   // Word request toggle, two stages.
  logic [1:0] ovr_sync;   // Overrun flag, two stages.
  logic       pend;       // A crossed word waits for buffer room.
  logic       buf_ready;  // Buffer can take a word.
  logic       j_evt;      // Start code seen, one cycle.
  logic       t_evt;      // End code seen, one cycle.

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      j_sync   <= '0;
      t_sync   <= '0;
      req_sync <= '0;
      ovr_sync <= '0;
    end else begin
      j_sync   <= {j_sync[1:0], ltog_j};
      t_sync   <= {t_sync[1:0], ltog_t};
      req_sync <= {req_sync[0], lreq};
      ovr_sync <= {ovr_sync[0], lover};
    end
  end

  assign j_evt      = j_sync[2] ^ j_sync[1];
  assign t_evt      = t_sync[2] ^ t_sync[1];
  assign rx_overrun = ovr_sync[1];

  // A word waits while the request level differs from the acknowledge level. Comparing levels
  // saves the cycle an edge detector would cost, which the round trip needs to keep up with the line.
  assign pend = req_sync[1] ^ lreq_ack;

  // The acknowledge waits for buffer room, so a stalled receiver holds the line side off.
  // It toggles only when the buffer really takes the word, so no word is acknowledged and lost.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lreq_ack <= 1'b0;
    end else if (pend && buf_ready && run) begin
      lreq_ack <= !lreq_ack;
    end
  end

  mct_fifo2 #(
    .WIDTH (5),
    .DEPTH (BUF_DEPTH)
  ) u_rx_buf (
    .mclk      (mclk),
    .nrst      (nrst),
    .in_data   (lword),
    .in_valid  (pend && run),
    .in_ready  (buf_ready),
    .out_data  (rx_symbol),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );

  // ---------------------------------------------------------------------------
  // Receive carrier
  // ---------------------------------------------------------------------------
  logic [3:0] on_cnt;     // Wait before receive carrier rises.
  logic [3:0] off_cnt;    // Wait before receive carrier falls.
  logic       rx_car;     // Carrier from the line.

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      on_cnt  <= '0;
      off_cnt <= '0;
      rx_car  <= 1'b0;
    end else begin
      if (j_evt) begin
        on_cnt <= 4'(mct_pkg::RX_ON_CYC);
      end else if (on_cnt == 4'h1) begin
        on_cnt <= '0;
        rx_car <= 1'b1;
      end else if (on_cnt != '0) begin
        on_cnt <= on_cnt - 1'b1;
      end
      if (t_evt) begin
        off_cnt <= 4'(mct_pkg::RX_OFF_CYC);
      end else if (off_cnt == 4'h1) begin
        off_cnt <= '0;
        rx_car  <= 1'b0;
      end else if (off_cnt != '0) begin
        off_cnt <= off_cnt - 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Heartbeat and jabber, 10 Mb/s half duplex only
  // ---------------------------------------------------------------------------
  logic [7:0]  sqe_cnt;   // Countdown through delay and pulse.
  logic        sqe;       // Heartbeat pulse toward the MAC.
  logic [24:0] jab_cnt;   // Cycles of transmission, then of jabber.
  logic        jabber;    // Jabber active.

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sqe_cnt <= '0;
    end else if (tx_en_d && !tx_en && !fast && half && !jabber) begin
      sqe_cnt <= 8'(mct_pkg::SQE_DLY_CYC + mct_pkg::SQE_LEN_CYC);
    end else if (sqe_cnt != '0) begin
      sqe_cnt <= sqe_cnt - 1'b1;
    end
  end

  assign sqe = (sqe_cnt != '0) && (sqe_cnt <= 8'(mct_pkg::SQE_LEN_CYC));

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      jab_cnt <= '0;
      jabber  <= 1'b0;
    end else if (jabber) begin
      if (jab_cnt >= 25'(JAB_OFF_CYC - 1)) begin
        jab_cnt <= '0;
        jabber  <= 1'b0;
      end else begin
        jab_cnt <= jab_cnt + 1'b1;
      end
    end else if (tx_en && !fast && half && run) begin
      if (jab_cnt >= 25'(JAB_ON_CYC - 1)) begin
        jab_cnt <= '0;
        jabber  <= 1'b1;
      end else begin
        jab_cnt <= jab_cnt + 1'b1;
      end
    end else begin
      jab_cnt <= '0;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs toward the MAC and the line
  // ---------------------------------------------------------------------------
  // echo only in half duplex
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mii_crs            <= 1'b0;
      mii_col            <= 1'b0;
      line_transmit_pair <= 1'b0;
    end else begin
      mii_crs            <= run && (rx_car || (half && tx_echo));
      mii_col            <= run && half && ((fast && rx_car && tx_echo) || sqe || jabber);
      line_transmit_pair <= run && tx_en && !jabber;
    end
  end

endmodule

// >>> src/mct_pkg.sv
// Holds the shared constants of the MII carrier and reset timing block.
// Assumes a 100 MHz system clock; the ms, ns and bit-time figures below are converted to cycle counts at that rate.
package mct_pkg;

  // ---------------------------------------------------------------------------
  // Clock rate and bit times
  // ---------------------------------------------------------------------------
  localparam int CLK_NS     = 10;   // System clock period in ns.
  localparam int BIT100_NS  = 10;   // One bit time at 100 Mb/s, in ns.
  localparam int BIT10_NS   = 100;  // One bit time at 10 Mb/s, in ns.
  localparam int CYC_PER_MS = 1_000_000 / CLK_NS;  // Clock cycles in one millisecond.

  // ---------------------------------------------------------------------------
  // Transmit carrier echo, in bit times
  // ---------------------------------------------------------------------------
  localparam int TX10_OFF_BITS  = 2;  // Carrier hold after transmit enable falls, 10 Mb/s.
  localparam int TX100_OFF_BITS = 3;  // Carrier hold after transmit enable falls, 100 Mb/s.
  localparam int TX10_OFF_CYC   = (TX10_OFF_BITS * BIT10_NS) / CLK_NS;
  localparam int TX100_OFF_CYC  = (TX100_OFF_BITS * BIT100_NS) / CLK_NS;

  // ---------------------------------------------------------------------------
  // Receive carrier, cycles added after the symbol event reaches this domain
  // ---------------------------------------------------------------------------
  localparam int RX_ON_CYC  = 2;    // Extra wait before carrier rises after /J/.
  localparam int RX_OFF_CYC = 6;    // Extra wait before carrier falls after /T/.

  // ---------------------------------------------------------------------------
  // Heartbeat pulse timing
  // ---------------------------------------------------------------------------
  localparam int SQE_DLY_NS  = 850;   // Delay from transmit enable falling to pulse start.
  localparam int SQE_LEN_NS  = 1000;  // Pulse length.
  localparam int SQE_DLY_CYC = SQE_DLY_NS / CLK_NS;
  localparam int SQE_LEN_CYC = SQE_LEN_NS / CLK_NS;

  // ---------------------------------------------------------------------------
  // Transmit clock half periods and line symbols
  // ---------------------------------------------------------------------------
  localparam int TXCLK100_HALF = 2;   // 25 MHz transmit clock from 100 MHz.
  localparam int TXCLK10_HALF  = 20;  // 2.5 MHz transmit clock from 100 MHz.
  localparam logic [4:0] SYM_J = 5'h18;  // Start-of-stream first code.
  localparam logic [4:0] SYM_T = 5'h0D;  // End-of-stream first code.
  localparam int SYM_BITS = 5;           // Bits in one line code group.

  // ---------------------------------------------------------------------------
  // Reset sequencing states
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_POR  = 4'b0001,  // Internal power-on reset running.
    ST_HOLD = 4'b0010,  // Hardware reset pin held low, device isolated.
    ST_INIT = 4'b0100,  // Initialising after the pin was released.
    ST_RUN  = 4'b1000   // Normal operation, transmit clock valid.
  } mct_state_t;

endpackage
